// ### rtl/phy_mode_pkg.sv
// Package with register map, field layout and timing constants of the PHY mode block
package phy_mode_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_OFFSET = 8'h0C;
  localparam logic [7:0] ACCEL_CTRL_OFFSET = 8'h17;
  localparam logic [7:0] SYNC_THR_OFFSET = 8'h15;
  localparam logic [7:0] STATUS_OFFSET = 8'h20;
  localparam logic [7:0] TIMING_OFFSET = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCRAMBLE_BIT = 5;
  localparam int SHAPING_BIT = 4;
  localparam int MODULATION_BIT = 3;
  localparam int SUBMODE_BIT = 2;
  localparam int RATE_LSB = 0;
  localparam int SHORT_ACK_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_RESET = 8'h24;
  localparam logic [7:0] ACCEL_CTRL_RESET = 8'h00;
  localparam logic [7:0] SYNC_THR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Symbol periods in microseconds and their cycle counts at 125 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SYM_BPSK20_US = 50;
  localparam int SYM_BPSK40_US = 25;
  localparam int SYM_OQ400_US = 40;
  localparam int SYM_OQ1000_US = 16;
  localparam int SYM_BPSK20_CYC = SYM_BPSK20_US * CLK_MHZ;
  localparam int SYM_BPSK40_CYC = SYM_BPSK40_US * CLK_MHZ;
  localparam int SYM_OQ400_CYC = SYM_OQ400_US * CLK_MHZ;
  localparam int SYM_OQ1000_CYC = SYM_OQ1000_US * CLK_MHZ;

  // Durations counted in symbol periods
  localparam logic [3:0] ACK_LONG_SYM = 4'hC;
  localparam logic [3:0] ACK_SHORT_LOW_SYM = 4'h2;
  localparam logic [3:0] ACK_SHORT_HIGH_SYM = 4'h3;
  localparam logic [3:0] ED_AUTO_HDR_SYM = 4'h2;
  localparam logic [3:0] ED_FULL_SYM = 4'h8;

  // Payload rate codes
  localparam logic [1:0] RATE_BASE = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] RATE_QUAD = 2'h2;

  // Chip spreading shortening factor for each rate code
  function automatic logic [2:0] spread_div(input logic [1:0] rate);
    case (rate)
      RATE_DOUBLE: spread_div = 3'h2;
      RATE_QUAD: spread_div = 3'h4;
      default: spread_div = 3'h1;
    endcase
  endfunction : spread_div

endpackage : phy_mode_pkg

// ### rtl/ed_if.sv
// Interface carrying energy-detection start and done between top and timer
interface ed_if;
  logic start; // One-cycle start pulse
  logic [3:0] symbols; // Length in symbol periods
  logic [15:0] sym_cycles; // Cycles per symbol period
  logic busy; // Measurement running
  logic done; // One-cycle end pulse

  modport ctrl (output start, output symbols, output sym_cycles, input busy, input done);
  modport timer (input start, input symbols, input sym_cycles, output busy, output done);
endinterface : ed_if

// ### rtl/ed_timer.sv
// Timer that measures a span of whole symbol periods
module ed_timer
  import phy_mode_pkg::*;
(
  input wire logic ref_clk, // Device clock
  input wire logic reset, // Async reset, active high
  ed_if.timer ed // Start and done handshake
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] cyc;
    logic [3:0] sym;
    logic [3:0] len;
    logic [15:0] per;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;

  // ----------------------------------------------------------------
  // Counting of cycles inside symbols and of symbols
  // ----------------------------------------------------------------
  // Length and period are latched at start; the length input only holds during the start pulse
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (!st_q.busy) begin
      if (ed.start) begin
        st_d.busy = 1'b1;
        st_d.cyc = 16'h0000;
        st_d.sym = 4'h0;
        st_d.len = ed.symbols;
        st_d.per = ed.sym_cycles;
      end
    end else if (st_q.cyc == st_q.per - 16'h0001) begin
      st_d.cyc = 16'h0000;
      if (st_q.sym == st_q.len - 4'h1) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.sym = st_q.sym + 4'h1;
      end
    end else begin
      st_d.cyc = st_q.cyc + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ed.busy = st_q.busy;
  assign ed.done = st_q.done;

endmodule : ed_timer

// ### rtl/symbol_clock.sv
// Symbol tick generator for the selected symbol period
module symbol_clock
  import phy_mode_pkg::*;
(
  input wire logic ref_clk, // Device clock
  input wire logic reset, // Async reset, active high
  input wire logic [15:0] period, // Cycles per symbol
  output logic tick // One-cycle pulse per symbol
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t st_q;
  tick_state_t st_d;

  // Free running divider, restarts cleanly if the period shrinks
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt >= period - 16'h0001) begin
      st_d.cnt = 16'h0000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule : symbol_clock

// ### rtl/phy_mode_config.sv
// PHY mode configuration register bank with derived timing
module phy_mode_config
  import phy_mode_pkg::*;
(
  input wire logic ref_clk, // 125 MHz device clock
  input wire logic reset, // Async reset, active high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [1:0] avs_response, // 00 ok, 10 slave error
  input wire logic transceiver_off_state, // Transceiver in off state (pin)
  input wire logic [7:0] rssi_level, // Received strength (pin)
  input wire logic frame_detect, // Raw header detect (pin)
  input wire logic ed_manual_req, // Software ED start (pin)
  input wire logic ed_auto_req, // Automatic ED start (pin)
  output logic sync_enable, // Allow frame synchronization
  output logic scramble_on, // Chip scrambler active
  output logic shaping_rc, // 1 raised cosine 0.8, 0 half-sine
  output logic oqpsk_sel, // 1 O-QPSK, 0 BPSK
  output logic fast_chips, // 1000/600 versus 400/300 kchip/s
  output logic [2:0] spread_shorten, // Code shortening for payload
  output logic payload_phase_high, // Current field uses payload rate
  output logic cs_allowed, // Carrier sense usable in CCA
  output logic lqi_valid, // Link quality meaningful
  output logic [15:0] symbol_cycles, // Symbol period in cycles
  output logic symbol_tick, // Pulse per symbol
  output logic [3:0] ack_symbols, // Ack delay in symbols
  output logic ed_busy, // Energy detection running
  output logic ed_done, // Energy detection finished
  input wire logic header_done, // Header sent, payload follows
  input wire logic frame_end // Frame finished
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] accel;
    logic [7:0] sync_thr;
    logic rd_ok;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [1:0] off_s;
    logic [1:0] det_s;
    logic [1:0] man_s;
    logic [1:0] auto_s;
    logic [7:0] rssi_s1;
    logic [7:0] rssi_s2;
    logic det_prev;
    logic man_prev;
    logic auto_prev;
    logic sync_q;
    logic payload;
    logic ignored_wr;
  } cfg_state_t;

  cfg_state_t st_q;
  cfg_state_t st_d;
  ed_if ed ();
  logic is_high_rate;
  logic [15:0] sym_cyc;
  logic hit;

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  // The receive path also reads these bits, so peers must match them
  assign oqpsk_sel = st_q.mode[MODULATION_BIT];
  assign fast_chips = st_q.mode[SUBMODE_BIT];
  assign is_high_rate = oqpsk_sel && (st_q.mode[1:0] != RATE_BASE);
  assign scramble_on = st_q.mode[SCRAMBLE_BIT] && oqpsk_sel
    && (st_q.mode[1:0] == RATE_QUAD);
  // Transmit filter only; no receive logic reads this bit
  assign shaping_rc = oqpsk_sel && fast_chips && st_q.mode[SHAPING_BIT];
  assign spread_shorten = oqpsk_sel ? spread_div(st_q.mode[1:0]) : 3'h1;
  assign cs_allowed = !is_high_rate;
  assign lqi_valid = !is_high_rate;
  assign payload_phase_high = st_q.payload && is_high_rate;

  // Symbol period depends only on modulation and chip rate, not payload rate
  always_comb begin
    case ({oqpsk_sel, fast_chips})
      2'b00: sym_cyc = 16'(SYM_BPSK20_CYC);
      2'b01: sym_cyc = 16'(SYM_BPSK40_CYC);
      2'b10: sym_cyc = 16'(SYM_OQ400_CYC);
      default: sym_cyc = 16'(SYM_OQ1000_CYC);
    endcase
  end
  assign symbol_cycles = sym_cyc;

  // Ack delay chooses short form only in the high rate modes
  always_comb begin
    if (st_q.accel[SHORT_ACK_BIT] && is_high_rate) begin
      ack_symbols = fast_chips ? ACK_SHORT_HIGH_SYM : ACK_SHORT_LOW_SYM;
    end else begin
      ack_symbols = ACK_LONG_SYM;
    end
  end

  // ----------------------------------------------------------------
  // Energy detection timing
  // ----------------------------------------------------------------
  // Manual request wins if both arrive together; manual is always 8 symbols
  assign ed.start = (st_q.man_s[1] && !st_q.man_prev) || (st_q.auto_s[1] && !st_q.auto_prev);
  assign ed.symbols = (st_q.auto_s[1] && !st_q.auto_prev && !(st_q.man_s[1] && !st_q.man_prev)
    && is_high_rate) ? ED_AUTO_HDR_SYM : ED_FULL_SYM;
  assign ed.sym_cycles = sym_cyc;
  assign ed_busy = ed.busy;
  assign ed_done = ed.done;

  ed_timer u_ed (
    .ref_clk(ref_clk),
    .reset(reset),
    .ed(ed)
  );

  symbol_clock u_sym (
    .ref_clk(ref_clk),
    .reset(reset),
    .period(sym_cyc),
    .tick(symbol_tick)
  );

  // ----------------------------------------------------------------
  // Bus decode and state update
  // ----------------------------------------------------------------
  assign hit = (avs_address == MODE_CTRL_OFFSET) || (avs_address == ACCEL_CTRL_OFFSET)
    || (avs_address == SYNC_THR_OFFSET) || (avs_address == STATUS_OFFSET)
    || (avs_address == TIMING_OFFSET);

  always_comb begin
    st_d = st_q;
    st_d.rd_ok = 1'b0;
    // Two-stage synchronisers for pins
    st_d.off_s = {st_q.off_s[0], transceiver_off_state};
    st_d.det_s = {st_q.det_s[0], frame_detect};
    st_d.man_s = {st_q.man_s[0], ed_manual_req};
    st_d.auto_s = {st_q.auto_s[0], ed_auto_req};
    st_d.rssi_s1 = rssi_level;
    st_d.rssi_s2 = st_q.rssi_s1;
    st_d.det_prev = st_q.det_s[1];
    st_d.man_prev = st_q.man_s[1];
    st_d.auto_prev = st_q.auto_s[1];
    // Zero threshold means no gating of weak frames
    if (st_q.det_s[1] && !st_q.det_prev) begin
      st_d.sync_q = (st_q.sync_thr == 8'h00) || (st_q.rssi_s2 >= st_q.sync_thr);
    end else if (!st_q.det_s[1]) begin
      st_d.sync_q = 1'b0;
    end
    if (header_done) begin
      st_d.payload = 1'b1;
    end
    if (frame_end) begin
      st_d.payload = 1'b0;
    end
    // Register access completes one cycle after the request
    if ((avs_read || avs_write) && !st_q.rd_ok) begin
      st_d.rd_ok = 1'b1;
      st_d.resp = hit ? 2'b00 : 2'b10;
      st_d.rdata = 32'h0000_0000;
      if (avs_write && avs_byteenable[0]) begin
        if (avs_address == MODE_CTRL_OFFSET) begin
          // Writes while running are dropped; mode must not shift mid-frame
          if (st_q.off_s[1]) begin
            st_d.mode = avs_writedata[7:0];
          end else begin
            st_d.ignored_wr = 1'b1;
          end
        end
        if (avs_address == ACCEL_CTRL_OFFSET) begin
          st_d.accel = avs_writedata[7:0];
        end
        if (avs_address == SYNC_THR_OFFSET) begin
          st_d.sync_thr = avs_writedata[7:0];
        end
        if (avs_address == STATUS_OFFSET) begin
          st_d.ignored_wr = 1'b0;
        end
      end
      if (avs_read) begin
        case (avs_address)
          MODE_CTRL_OFFSET: st_d.rdata = {24'h000000, st_q.mode};
          ACCEL_CTRL_OFFSET: st_d.rdata = {24'h000000, st_q.accel};
          SYNC_THR_OFFSET: st_d.rdata = {24'h000000, st_q.sync_thr};
          STATUS_OFFSET: st_d.rdata = {24'h000000, st_q.ignored_wr, scramble_on,
            is_high_rate, ed.busy, cs_allowed, lqi_valid, st_q.sync_q, st_q.off_s[1]};
          TIMING_OFFSET: st_d.rdata = {12'h000, ack_symbols, sym_cyc};
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.mode <= MODE_CTRL_RESET;
      st_q.accel <= ACCEL_CTRL_RESET;
      st_q.sync_thr <= SYNC_THR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_q.rd_ok;
  assign avs_readdata = st_q.rdata;
  assign avs_response = st_q.resp;
  assign sync_enable = st_q.sync_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Mode write at the edge that takes it, while waitrequest is still high
  sequence wr_mode_s;
    avs_write && avs_waitrequest && avs_address == MODE_CTRL_OFFSET && avs_byteenable[0];
  endsequence

  mode_locked_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_mode_s and !st_q.off_s[1]) |=> $stable(st_q.mode))
    else $error("mode changed while transceiver on");
  mode_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_mode_s and st_q.off_s[1]) |=> st_q.mode == $past(avs_writedata[7:0]))
    else $error("mode write not stored");
  bpsk_period_a: assert property (@(posedge ref_clk) disable iff (reset)
    !oqpsk_sel |-> symbol_cycles == (fast_chips ? 16'h0C35 : 16'h186A))
    else $error("bpsk symbol period wrong");
  oqpsk_period_a: assert property (@(posedge ref_clk) disable iff (reset)
    oqpsk_sel |-> symbol_cycles == (fast_chips ? 16'h07D0 : 16'h1388))
    else $error("oqpsk symbol period wrong");
  ack_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
    (is_high_rate && st_q.accel[SHORT_ACK_BIT]) |-> ack_symbols == (fast_chips ? 4'h3 : 4'h2))
    else $error("short ack delay wrong");
  scramble_a: assert property (@(posedge ref_clk) disable iff (reset)
    scramble_on |-> (oqpsk_sel && st_q.mode[1:0] == 2'h2 && st_q.mode[SCRAMBLE_BIT]))
    else $error("scrambler on in wrong mode");
  no_cs_a: assert property (@(posedge ref_clk) disable iff (reset)
    is_high_rate |-> !cs_allowed && !lqi_valid)
    else $error("carrier sense allowed at high rate");
  ed_len_a: assert property (@(posedge ref_clk) disable iff (reset)
    (ed.start && !ed.busy) |=> ed.busy [*8])
    else $error("energy detection ended too early");
  spread_a: assert property (@(posedge ref_clk) disable iff (reset)
    (oqpsk_sel && st_q.mode[1:0] == 2'h2) |-> spread_shorten == 3'h4)
    else $error("spreading not shortened by four");
  sync_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sync_enable && st_q.sync_thr != 8'h00 && $rose(sync_enable))
    |-> $past(st_q.rssi_s2) >= st_q.sync_thr)
    else $error("synchronized below threshold");
  payload_a: assert property (@(posedge ref_clk) disable iff (reset)
    !st_q.payload |-> !payload_phase_high)
    else $error("header sent at high rate");

endmodule : phy_mode_config

// ### bench/peer_radio.sv
// Peer transceiver model that sends frames toward the block
module peer_radio
  import phy_mode_pkg::*;
(
  input wire logic ref_clk, // Device clock
  output logic [7:0] rssi_level, // Strength seen by the block
  output logic frame_detect, // Header found on air
  output logic header_done, // Header sent, payload follows
  output logic frame_end // Frame finished
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle air
  // ----------------------------------------------------------------
  // Quiet channel reads as the noise floor, not the last frame
  initial begin
    rssi_level = 8'h00;
    frame_detect = 1'b0;
    header_done = 1'b0;
    frame_end = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame phases
  // ----------------------------------------------------------------
  // Peer holds the same modulation, sub-mode, rate and scrambler
  // Its shaping may differ, the receiver does not care
  task automatic start_frame(input logic [7:0] level);
    @(posedge ref_clk);
    rssi_level <= level;
    repeat (3) @(posedge ref_clk);
    frame_detect <= 1'b1;
  endtask : start_frame

  // Header goes out at base rate, payload phase starts after it
  task automatic end_header;
    @(posedge ref_clk);
    header_done <= 1'b1;
    @(posedge ref_clk);
    header_done <= 1'b0;
  endtask : end_header

  task automatic end_frame;
    @(posedge ref_clk);
    frame_end <= 1'b1;
    frame_detect <= 1'b0;
    rssi_level <= 8'h00;
    @(posedge ref_clk);
    frame_end <= 1'b0;
  endtask : end_frame
endmodule : peer_radio

// ### bench/phy_mode_config_high_rate_tb_top.sv
// Self-checking bench of the PHY mode register bank
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module phy_mode_config_high_rate_tb_top
  import phy_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, transceiver_off_state;
  logic [7:0] avs_address, rssi_level;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [1:0] avs_response, rresp;
  logic frame_detect, ed_manual_req, ed_auto_req, header_done, frame_end;
  logic sync_enable, scramble_on, shaping_rc, oqpsk_sel, fast_chips, payload_phase_high;
  logic cs_allowed, lqi_valid, symbol_tick, ed_busy, ed_done;
  logic [2:0] spread_shorten;
  logic [15:0] symbol_cycles;
  logic [3:0] ack_symbols;
  int miscompares = 0;
  int num_checks = 0;
  int cyc;

  // Flags are {scramble, shaping, oqpsk, fast chips, carrier sense}
  typedef struct {
    logic [7:0] mode;
    logic [7:0] accel;
    logic [4:0] flg;
    logic [2:0] spr;
    logic [15:0] sym;
    logic [3:0] ack;
  } row_t;
  row_t rows [12] = '{
    '{8'h00, 8'h00, 5'h01, 3'h1, 16'h186A, 4'hC}, '{8'h24, 8'h04, 5'h03, 3'h1, 16'h0C35, 4'hC},
    '{8'h08, 8'h04, 5'h05, 3'h1, 16'h1388, 4'hC}, '{8'h29, 8'h04, 5'h04, 3'h2, 16'h1388, 4'h2},
    '{8'h2A, 8'h04, 5'h14, 3'h4, 16'h1388, 4'h2}, '{8'h0A, 8'h00, 5'h04, 3'h4, 16'h1388, 4'hC},
    '{8'h2B, 8'h04, 5'h04, 3'h1, 16'h1388, 4'h2}, '{8'h2C, 8'h04, 5'h07, 3'h1, 16'h07D0, 4'hC},
    '{8'h2D, 8'h04, 5'h06, 3'h2, 16'h07D0, 4'h3}, '{8'h3E, 8'h04, 5'h1E, 3'h4, 16'h07D0, 4'h3},
    '{8'hDE, 8'h00, 5'h0E, 3'h4, 16'h07D0, 4'hC}, '{8'h1C, 8'h00, 5'h0F, 3'h1, 16'h07D0, 4'hC}};

  // ----------------------------------------------------------------
  // Design and peer
  // ----------------------------------------------------------------
  phy_mode_config DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .transceiver_off_state(transceiver_off_state), .rssi_level(rssi_level),
    .frame_detect(frame_detect), .ed_manual_req(ed_manual_req), .ed_auto_req(ed_auto_req),
    .sync_enable(sync_enable), .scramble_on(scramble_on), .shaping_rc(shaping_rc),
    .oqpsk_sel(oqpsk_sel), .fast_chips(fast_chips), .spread_shorten(spread_shorten),
    .payload_phase_high(payload_phase_high), .cs_allowed(cs_allowed), .lqi_valid(lqi_valid),
    .symbol_cycles(symbol_cycles), .symbol_tick(symbol_tick), .ack_symbols(ack_symbols),
    .ed_busy(ed_busy), .ed_done(ed_done), .header_done(header_done), .frame_end(frame_end));

  peer_radio peer (.ref_clk(ref_clk), .rssi_level(rssi_level), .frame_detect(frame_detect),
    .header_done(header_done), .frame_end(frame_end));

  // ----------------------------------------------------------------
  // Clock and tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // One bus access; holds the request until a rising edge samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    rdata = avs_readdata;
    rresp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // Counts the busy cycles of one energy measurement
  task automatic ed_run(input logic manual);
    int n = 0;
    @(posedge ref_clk);
    if (manual) ed_manual_req <= 1'b1;
    else ed_auto_req <= 1'b1;
    while (ed_busy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    cyc = 0;
    while (ed_busy === 1'b1 && cyc < 20000) begin
      @(negedge ref_clk);
      cyc++;
    end
    `CHK("ed_done", 1'b1, ed_done)
    if (n >= 20 || cyc >= 20000) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge ref_clk);
    ed_manual_req <= 1'b0;
    ed_auto_req <= 1'b0;
  endtask : ed_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    transceiver_off_state = 1'b1;
    ed_manual_req = 1'b0;
    ed_auto_req = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("oqpsk_rst", 1'b0, oqpsk_sel)
    `CHK("fast_rst", 1'b1, fast_chips)
    `CHK("spread_rst", 3'h1, spread_shorten)
    bus(1'b0, MODE_CTRL_OFFSET, 8'h00);
    `CHK("mode_rst", 32'h00000024, rdata)
    `CHK("resp_ok", 2'b00, rresp)
    // Mode table, written while the transceiver is off
    foreach (rows[i]) begin
      bus(1'b1, ACCEL_CTRL_OFFSET, rows[i].accel);
      bus(1'b1, MODE_CTRL_OFFSET, rows[i].mode);
      bus(1'b0, MODE_CTRL_OFFSET, 8'h00);
      `CHK("mode_rd", {24'h000000, rows[i].mode}, rdata)
      `CHK("flags", rows[i].flg, {scramble_on, shaping_rc, oqpsk_sel, fast_chips, cs_allowed})
      `CHK("lqi", rows[i].flg[0], lqi_valid)
      `CHK("spread", rows[i].spr, spread_shorten)
      `CHK("sym", rows[i].sym, symbol_cycles)
      `CHK("ack", rows[i].ack, ack_symbols)
      bus(1'b0, TIMING_OFFSET, 8'h00);
      `CHK("timing", {rows[i].ack, rows[i].sym}, rdata[19:0])
    end
    // Write while the transceiver runs is dropped and flagged
    transceiver_off_state <= 1'b0;
    repeat (3) @(posedge ref_clk);
    bus(1'b1, MODE_CTRL_OFFSET, 8'h08);
    bus(1'b0, MODE_CTRL_OFFSET, 8'h00);
    `CHK("mode_kept", 32'h0000001C, rdata)
    bus(1'b0, STATUS_OFFSET, 8'h00);
    `CHK("ignored", 1'b1, rdata[7])
    transceiver_off_state <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b1, STATUS_OFFSET, 8'h00);
    bus(1'b0, STATUS_OFFSET, 8'h00);
    `CHK("ignored_clr", 1'b0, rdata[7])
    bus(1'b0, 8'h40, 8'h00);
    `CHK("unmapped", 34'h200000000, {rresp, rdata})
    // Weak frame must not synchronise, strong one must; high rate so payload phase shows
    bus(1'b1, MODE_CTRL_OFFSET, 8'h2E);
    bus(1'b1, SYNC_THR_OFFSET, 8'h40);
    peer.start_frame(8'h30);
    repeat (10) @(negedge ref_clk);
    `CHK("sync_weak", 1'b0, sync_enable)
    peer.end_frame();
    peer.start_frame(8'h50);
    cyc = 0;
    while (sync_enable !== 1'b1 && cyc < 20) begin
      @(negedge ref_clk);
      cyc++;
    end
    `CHK("sync_strong", 1'b1, sync_enable)
    `CHK("hdr_phase", 1'b0, payload_phase_high)
    peer.end_header();
    @(negedge ref_clk);
    `CHK("pay_phase", 1'b1, payload_phase_high)
    peer.end_frame();
    @(negedge ref_clk);
    `CHK("end_phase", 1'b0, payload_phase_high)
    // Energy detection in the 1000 kbit/s mode, 2000 cycles a symbol
    bus(1'b1, MODE_CTRL_OFFSET, 8'h2E);
    ed_run(1'b0);
    `CHK("ed_auto", 1'b1, (cyc >= 3998 && cyc <= 4002))
    ed_run(1'b1);
    `CHK("ed_manual", 1'b1, (cyc >= 15998 && cyc <= 16002))
    // Symbol tick spacing follows the selected symbol period
    cyc = 0;
    do begin
      @(negedge ref_clk);
      cyc++;
    end while (symbol_tick !== 1'b1 && cyc < 3000);
    cyc = 0;
    do begin
      @(negedge ref_clk);
      cyc++;
    end while (symbol_tick !== 1'b1 && cyc < 3000);
    `CHK("tick", 2000, cyc)
    // Reset in mid-run brings the mode register back to its reset value
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(negedge ref_clk);
    bus(1'b0, MODE_CTRL_OFFSET, 8'h00);
    `CHK("mode_rst2", 32'h00000024, rdata)
    tally_and_finish();
  end
endmodule : phy_mode_config_high_rate_tb_top
